// ==== shared/rfm_pkg.sv ====
package rfm_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] MASK_A_OFF = 8'hA2;
  localparam logic [7:0] MASK_B_OFF = 8'hA3;
  localparam logic [7:0] DISCH_OFF  = 8'hAD;
  localparam logic [7:0] AUX_OFF    = 8'hAE;
  localparam logic [7:0] STAT_A_OFF = 8'hB2;
  localparam logic [7:0] STAT_B_OFF = 8'hB3;

  // Values after reset
  localparam logic [7:0] MASK_A_RST = 8'hC0;
  localparam logic [7:0] MASK_B_RST = 8'h37;
  localparam logic [7:0] DISCH_RST  = 8'h61;
  localparam logic [7:0] AUX_RST    = 8'h7C;

  // Field positions
  localparam int MB_RO_BIT    = 7;
  localparam int DIS_TERM_BIT = 4;
  localparam int AUX_DIS_LO   = 6;
  localparam int AUX_KEEP_BIT = 5;
  localparam int AUX_VID_LO   = 1;
  localparam int AUX_EN_BIT   = 0;

  // Rail index in the fault vector; 0 to 5 are the step-down converters
  localparam int NRAIL  = 13;
  localparam int R_SWA  = 6;
  localparam int R_L2   = 7;
  localparam int R_L3   = 8;
  localparam int R_SWB  = 9;
  localparam int R_TERM = 10;
  localparam int R_L1   = 11;
  localparam int R_A5V  = 12;

  // Serial bus target address, arbitrary value
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_PTR  = 3'b010,
    I_WDAT = 3'b011,
    I_RDAT = 3'b100,
    I_ACK  = 3'b101,
    I_RACK = 3'b110
  } rfm_i2c_state_e;

endpackage

// ==== core/rfm_sync.sv ====
`timescale 1ns/1ps
module rfm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ==== core/rfm_i2c.sv ====
`timescale 1ns/1ps
module rfm_i2c #(
  parameter logic [6:0] DEV_ADDR = rfm_pkg::DEV_ADDR_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rdata,
  output logic            sda_oe,
  output logic            wr_en,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  rfm_pkg::rfm_i2c_state_e st;
  rfm_pkg::rfm_i2c_state_e after;
  logic [7:0] sh;
  logic [7:0] b;
  logic [2:0] cnt;
  logic       scl_q;
  logic       sda_q;
  logic       bump;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;

  assign start = scl & scl_q & sda_q & ~sda;
  assign stop  = scl & scl_q & ~sda_q & sda;
  assign rise  = scl & ~scl_q;
  assign fall  = ~scl & scl_q;
  assign b     = {sh[6:0], sda};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st     <= rfm_pkg::I_IDLE;
      after  <= rfm_pkg::I_IDLE;
      sh     <= 8'h00;
      cnt    <= 3'h0;
      bump   <= 1'b0;
      sda_oe <= 1'b0;
      wr_en  <= 1'b0;
      addr   <= 8'h00;
      wdata  <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (start)
      begin
        st     <= rfm_pkg::I_ADDR;
        cnt    <= 3'h0;
        sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        st     <= rfm_pkg::I_IDLE;
        sda_oe <= 1'b0;
      end
      else if (rise)
      begin
        case (st)
          rfm_pkg::I_ADDR, rfm_pkg::I_PTR, rfm_pkg::I_WDAT:
          begin
            sh  <= b;
            cnt <= cnt + 3'h1;
            if (cnt == rfm_pkg::BIT_LAST)
            begin
              st   <= rfm_pkg::I_ACK;
              bump <= (st == rfm_pkg::I_WDAT);
              if (st == rfm_pkg::I_ADDR)
              begin
                // Foreign address: stay silent until the next start
                if (b[7:1] != DEV_ADDR)
                  st <= rfm_pkg::I_IDLE;
                after <= b[0] ? rfm_pkg::I_RDAT : rfm_pkg::I_PTR;
              end
              else if (st == rfm_pkg::I_PTR)
              begin
                addr  <= b;
                after <= rfm_pkg::I_WDAT;
              end
              else
              begin
                wdata <= b;
                wr_en <= 1'b1;
              end
            end
          end
          rfm_pkg::I_ACK:
          begin
            st  <= after;
            cnt <= 3'h0;
            if (bump)
              addr <= addr + 8'h01;
          end
          rfm_pkg::I_RDAT:
          begin
            cnt <= cnt + 3'h1;
            if (cnt == rfm_pkg::BIT_LAST)
              st <= rfm_pkg::I_RACK;
          end
          rfm_pkg::I_RACK:
          begin
            cnt  <= 3'h0;
            addr <= addr + 8'h01;
            st   <= sda ? rfm_pkg::I_IDLE : rfm_pkg::I_RDAT;
          end
          default:
            st <= rfm_pkg::I_IDLE;
        endcase
      end
      else if (fall)
      begin
        case (st)
          rfm_pkg::I_ACK:  sda_oe <= 1'b1;
          rfm_pkg::I_RDAT: sda_oe <= ~rdata[rfm_pkg::BIT_LAST - cnt];
          default:         sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ==== core/rfm_ldo_regs.sv ====
`timescale 1ns/1ps
module rfm_ldo_regs #(
  parameter logic [6:0] DEV_ADDR = rfm_pkg::DEV_ADDR_DEF,
  parameter logic [7:0] AUX_RESET = rfm_pkg::AUX_RST
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic [rfm_pkg::NRAIL-1:0] rail_fault_in,
  input  wire logic                     emerg_shutdown_active,
  output logic                          shutdown_start,
  output logic      [rfm_pkg::NRAIL-1:0] rail_fault_flag,
  output logic                          ldo_rail_one_on,
  output logic      [3:0]               ldo_rail_one_voltage_code,
  output logic      [1:0]               ldo_rail_one_discharge_sel,
  output logic                          term_ldo_discharge
);
  localparam int N = rfm_pkg::NRAIL;

  logic [7:0]   power_fault_mask_a;
  logic [7:0]   power_fault_mask_b;
  logic [7:0]   discharge_control_four;
  logic [7:0]   aux_ldo_control;
  logic [1:0]   bus_sync;
  logic [N-1:0] fault_sync;
  logic [N-1:0] mask_vec;
  logic [N-1:0] hot;
  logic [N-1:0] clr;
  logic [N-1:0] next_flag;
  logic         any_hot;
  logic         any_hot_q;
  logic         wr_en;
  logic [7:0]   addr;
  logic [7:0]   wdata;
  logic [7:0]   rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Pair flag shows on both code bits, like its two-bit mask
  function automatic logic [7:0] stat_b_view(input logic [rfm_pkg::NRAIL-1:0] f);
    stat_b_view = {2'b00, f[rfm_pkg::R_A5V], f[rfm_pkg::R_L1], f[rfm_pkg::R_TERM],
                   f[rfm_pkg::R_SWB], f[rfm_pkg::R_SWB], f[rfm_pkg::R_L3]};
  endfunction

  rfm_sync #(
    .W (2)
  ) u_bus_sync (
    .clk (clk),
    .rst (rst),
    .d   ({scl_in, sda_in}),
    .q   (bus_sync)
  );

  rfm_sync #(
    .W (N)
  ) u_fault_sync (
    .clk (clk),
    .rst (rst),
    .d   (rail_fault_in),
    .q   (fault_sync)
  );

  rfm_i2c #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk    (clk),
    .rst    (rst),
    .scl    (bus_sync[1]),
    .sda    (bus_sync[0]),
    .rdata  (rdata),
    .sda_oe (sda_oe),
    .wr_en  (wr_en),
    .addr   (addr),
    .wdata  (wdata)
  );

  // Open drain: only the enable moves
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      power_fault_mask_a <= rfm_pkg::MASK_A_RST;
    else if (wr_en && hit(addr, rfm_pkg::MASK_A_OFF))
      power_fault_mask_a <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      power_fault_mask_b <= rfm_pkg::MASK_B_RST;
    else if (wr_en && hit(addr, rfm_pkg::MASK_B_OFF))
    begin
      // Bit 7 keeps its value, bit 6 just stores
      power_fault_mask_b[6:0] <= wdata[6:0];
      power_fault_mask_b[rfm_pkg::MB_RO_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      discharge_control_four <= rfm_pkg::DISCH_RST;
    else if (wr_en && hit(addr, rfm_pkg::DISCH_OFF))
      discharge_control_four <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      aux_ldo_control <= AUX_RESET;
    else if (wr_en && hit(addr, rfm_pkg::AUX_OFF))
      aux_ldo_control <= wdata;
  end

  // Field outputs; reserved bits go nowhere
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      term_ldo_discharge         <= rfm_pkg::DISCH_RST[rfm_pkg::DIS_TERM_BIT];
      ldo_rail_one_discharge_sel <= AUX_RESET[rfm_pkg::AUX_DIS_LO +: 2];
      ldo_rail_one_voltage_code  <= AUX_RESET[rfm_pkg::AUX_VID_LO +: 4];
      ldo_rail_one_on            <= 1'b0;
    end
    else
    begin
      term_ldo_discharge <= discharge_control_four[rfm_pkg::DIS_TERM_BIT];
      ldo_rail_one_discharge_sel <= aux_ldo_control[rfm_pkg::AUX_DIS_LO +: 2];
      ldo_rail_one_voltage_code <= aux_ldo_control[rfm_pkg::AUX_VID_LO +: 4];
      ldo_rail_one_on <= aux_ldo_control[rfm_pkg::AUX_EN_BIT]
        && (!emerg_shutdown_active || aux_ldo_control[rfm_pkg::AUX_KEEP_BIT]);
    end
  end

  // Mask per rail in fault-vector order
  always_comb
  begin
    mask_vec[5:0] = power_fault_mask_a[5:0];
    mask_vec[rfm_pkg::R_SWA] = power_fault_mask_a[6];
    mask_vec[rfm_pkg::R_L2] = power_fault_mask_a[7];
    mask_vec[rfm_pkg::R_L3] = power_fault_mask_b[0];
    // Reserved pair codes count as masked, erring toward staying up
    mask_vec[rfm_pkg::R_SWB] = |power_fault_mask_b[2:1];
    mask_vec[rfm_pkg::R_TERM] = power_fault_mask_b[3];
    mask_vec[rfm_pkg::R_L1] = power_fault_mask_b[4];
    mask_vec[rfm_pkg::R_A5V] = power_fault_mask_b[5];
  end

  assign hot     = fault_sync & ~mask_vec;
  assign any_hot = |hot;

  // One pulse per onset; later faults join the running sequence
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      any_hot_q      <= 1'b0;
      shutdown_start <= 1'b0;
    end
    else
    begin
      any_hot_q      <= any_hot;
      shutdown_start <= any_hot && !any_hot_q;
    end
  end

  // Write-one-to-clear strobes
  always_comb
  begin
    clr = '0;
    if (wr_en && hit(addr, rfm_pkg::STAT_A_OFF))
      clr[7:0] = wdata;
    if (wr_en && hit(addr, rfm_pkg::STAT_B_OFF))
    begin
      clr[rfm_pkg::R_L3]   = wdata[0];
      clr[rfm_pkg::R_SWB]  = wdata[1] | wdata[2];
      clr[rfm_pkg::R_TERM] = wdata[3];
      clr[rfm_pkg::R_L1]   = wdata[4];
      clr[rfm_pkg::R_A5V]  = wdata[5];
    end
  end

  // A fault still present beats the clear
  assign next_flag = fault_sync | (rail_fault_flag & ~clr);

  always_ff @(posedge clk)
  begin
    if (rst)
      rail_fault_flag <= '0;
    else
      rail_fault_flag <= next_flag;
  end

  always_comb
  begin
    case (addr)
      rfm_pkg::MASK_A_OFF: rdata = power_fault_mask_a;
      rfm_pkg::MASK_B_OFF: rdata = power_fault_mask_b;
      rfm_pkg::DISCH_OFF:  rdata = discharge_control_four;
      rfm_pkg::AUX_OFF:    rdata = aux_ldo_control;
      rfm_pkg::STAT_A_OFF: rdata = rail_fault_flag[7:0];
      rfm_pkg::STAT_B_OFF: rdata = stat_b_view(rail_fault_flag);
      default:             rdata = 8'h00;
    endcase
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_quiet;
    !any_hot_q;
  endsequence

  sequence s_aux_write;
    wr_en && hit(addr, rfm_pkg::AUX_OFF);
  endsequence

  property p_kills(f, m);
    s_quiet ##0 (f && !m) |=> shutdown_start;
  endproperty

  property p_spared(f, m);
    s_quiet ##0 (f && m && (hot == '0)) |=> !shutdown_start;
  endproperty

  ldo_two_mask_a: assert property (p_spared(fault_sync[rfm_pkg::R_L2], mask_vec[rfm_pkg::R_L2]))
    else $error("masked rail-two fault started shutdown");

  ldo_two_open_a: assert property (p_kills(fault_sync[rfm_pkg::R_L2], power_fault_mask_a[7]))
    else $error("unmasked rail-two fault ignored");

  switch_a_mask_a: assert property (p_kills(fault_sync[rfm_pkg::R_SWA], power_fault_mask_a[6]))
    else $error("switch A fault mask wrong");

  step_down_mask_a: assert property (p_kills(fault_sync[0], power_fault_mask_a[0]))
    else $error("step-down one fault mask wrong");

  mask_a_reset_a: assert property ($fell(rst) |-> power_fault_mask_a == 8'hC0)
    else $error("mask A reset value wrong");

  mask_a_write_a: assert property (wr_en && addr == 8'hA2 |=> power_fault_mask_a == $past(wdata))
    else $error("mask A write lost");

  mask_b_ro_a: assert property (wr_en && addr == 8'hA3 |=> power_fault_mask_b[7] == 1'b0 && power_fault_mask_b[6] == $past(wdata[6]))
    else $error("mask B reserved bits wrong");

  analog_mask_a: assert property (p_kills(fault_sync[rfm_pkg::R_A5V], power_fault_mask_b[5]))
    else $error("analog supply mask wrong");

  ldo_one_mask_a: assert property (p_spared(fault_sync[rfm_pkg::R_L1], power_fault_mask_b[4]))
    else $error("rail-one mask wrong");

  term_mask_a: assert property (p_kills(fault_sync[rfm_pkg::R_TERM], power_fault_mask_b[3]))
    else $error("termination mask wrong");

  pair_mask_a: assert property (p_kills(fault_sync[rfm_pkg::R_SWB], power_fault_mask_b[2:1] != 2'b00))
    else $error("switch pair mask wrong");

  ldo_three_mask_a: assert property (p_kills(fault_sync[rfm_pkg::R_L3], power_fault_mask_b[0]))
    else $error("rail-three mask wrong");

  disch_reset_a: assert property ($fell(rst) |=> term_ldo_discharge == 1'b0 && discharge_control_four == 8'h61)
    else $error("discharge reset wrong");

  disch_sel_a: assert property (s_aux_write |=> ##1 ldo_rail_one_discharge_sel == $past(wdata[7:6], 2))
    else $error("discharge select not applied");

  emerg_keep_a: assert property (aux_ldo_control[0] && aux_ldo_control[5] |=> ldo_rail_one_on)
    else $error("rail one dropped despite keep");

  emerg_off_a: assert property (emerg_shutdown_active && !aux_ldo_control[5] |=> !ldo_rail_one_on)
    else $error("rail one kept through emergency");

  vcode_a: assert property (s_aux_write |=> ##1 ldo_rail_one_voltage_code == $past(wdata[4:1], 2))
    else $error("voltage code not applied");

  enable_a: assert property (s_aux_write ##1 !emerg_shutdown_active |=> ldo_rail_one_on == $past(wdata[0], 2))
    else $error("enable bit not applied");

  flag_sticky_a: assert property (rail_fault_flag[0] && !clr[0] |=> rail_fault_flag[0])
    else $error("fault flag dropped without clear");

  flag_set_a: assert property (fault_sync[0] |=> rail_fault_flag[0])
    else $error("fault lost against clear");

  shutdown_cause_a: assert property (shutdown_start |-> $past(any_hot) && !$past(any_hot_q))
    else $error("shutdown without unmasked fault");

  ro_write_a: assert property (power_fault_mask_b[7] == 1'b0)
    else $error("read-only bit changed");

  step_six_a: assert property (p_kills(fault_sync[5], power_fault_mask_a[5]))
    else $error("step-down six fault mask wrong");

  pair_spared_a: assert property (p_spared(fault_sync[rfm_pkg::R_SWB], power_fault_mask_b[2:1] == 2'b11))
    else $error("masked switch pair fault started shutdown");

  ldo_three_spare_a: assert property (p_spared(fault_sync[rfm_pkg::R_L3], power_fault_mask_b[0]))
    else $error("masked rail-three fault started shutdown");

  term_disch_a: assert property (wr_en && hit(addr, rfm_pkg::DISCH_OFF) |=> ##1 term_ldo_discharge == $past(wdata[4], 2))
    else $error("termination discharge not applied");

  mask_b_write_a: assert property (wr_en && hit(addr, rfm_pkg::MASK_B_OFF) |=> power_fault_mask_b[5:0] == $past(wdata[5:0]))
    else $error("mask B write lost");

  flag_clear_a: assert property (rail_fault_flag[rfm_pkg::R_L2] && clr[rfm_pkg::R_L2] && !fault_sync[rfm_pkg::R_L2] |=> !rail_fault_flag[rfm_pkg::R_L2])
    else $error("fault flag not cleared");

  stat_b_read_a: assert property (addr == rfm_pkg::STAT_B_OFF |-> rdata == stat_b_view(rail_fault_flag))
    else $error("status B read layout wrong");

endmodule

// ==== test/rfm_host.sv ====
`timescale 1ns/1ps
module rfm_host #(
  parameter int HALF = 8
) (
  input  wire logic       clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_low,
  output logic            rd_valid,
  output logic      [7:0] rd_byte
);
  int nack_count = 0;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end
  // Changes land 1 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Driving 1 releases the line; a silent target floats to the pull-up
  task automatic bit_cycle(input logic b, output logic s);
    sda_low = ~b;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF / 2);
    s = sda_line;
    tick(HALF / 2);
    scl = 1'b0;
    tick(HALF / 2);
  endtask
  task automatic start_bit();
    sda_low = 1'b0;
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(HALF / 2);
  endtask
  task automatic stop_bit();
    sda_low = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  task automatic send_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_cycle(v[i], a);
    bit_cycle(1'b1, a);
    if (a)
      nack_count++;
  endtask
  // n of zero writes d, otherwise reads n bytes from off
  task automatic xfer(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d,
                      input int n);
    logic [7:0] v;
    logic       s;
    start_bit();
    send_byte({dev, 1'b0});
    send_byte(off);
    if (n == 0)
      send_byte(d);
    else
    begin
      stop_bit();
      start_bit();
      send_byte({dev, 1'b1});
    end
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
        bit_cycle(1'b1, v[i]);
      rd_byte = v;
      rd_valid = 1'b1;
      tick(1);
      rd_valid = 1'b0;
      bit_cycle(k == n - 1, s);
    end
    stop_bit();
  endtask
endmodule

// ==== test/rfm_ldo_regs_tb_top.sv ====
`timescale 1ns/1ps
module rfm_ldo_regs_tb_top;
  localparam logic [6:0] DEV = rfm_pkg::DEV_ADDR_DEF;
  logic                      clk;
  logic                      rst;
  logic                      emerg;
  logic [rfm_pkg::NRAIL-1:0] fault_in;
  logic [rfm_pkg::NRAIL-1:0] flags;
  logic                      scl;
  logic                      sda_low;
  logic                      sda_oe;
  logic                      sda_out;
  logic                      rd_valid;
  logic [7:0]                rd_byte;
  logic                      sd_pulse;
  logic                      rail_on;
  logic [3:0]                vcode;
  logic [1:0]                dsel;
  logic                      tdis;
  logic [7:0]                exp_q[$];
  logic [31:0]               seed;
  int                        fail_count = 0;
  int                        num_checks = 0;
  int                        sd_count;
  // Unknown drive before reset must not look like a pulled-low line
  wire sda_line = ~(sda_low | (sda_oe === 1'b1));
  rfm_ldo_regs u_rfm_ldo_regs (
    .clk                        (clk),
    .rst                        (rst),
    .scl_in                     (scl),
    .sda_in                     (sda_line),
    .sda_out                    (sda_out),
    .sda_oe                     (sda_oe),
    .rail_fault_in              (fault_in),
    .emerg_shutdown_active      (emerg),
    .shutdown_start             (sd_pulse),
    .rail_fault_flag            (flags),
    .ldo_rail_one_on            (rail_on),
    .ldo_rail_one_voltage_code  (vcode),
    .ldo_rail_one_discharge_sel (dsel),
    .term_ldo_discharge         (tdis)
  );
  rfm_host u_rfm_host (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (sda_low),
    .rd_valid (rd_valid),
    .rd_byte  (rd_byte)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    u_rfm_host.xfer(DEV, off, d, 0);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge clk)
  begin
    if (rst)
      sd_count <= 0;
    else if (sd_pulse === 1'b1)
      sd_count <= sd_count + 1;
  end
  always @(posedge clk)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("read extra", 16'(rd_byte), 16'hFFFF);
      else
        check("read data", 16'(rd_byte), 16'(exp_q.pop_front()));
    end
  end
  task automatic fault_case(input int idx, input logic [7:0] coff, input logic [7:0] cval,
                            input int sd_exp);
    int sd0;
    int n;
    sd0 = sd_count;
    fault_in[idx] = 1'b1;
    n = 0;
    while (flags[idx] !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    cyc(4);
    check("fault flag", 16'(flags[idx]), 16'h0001);
    if (n >= 20)
      stop_test();
    check("shutdown", 16'(sd_count - sd0), 16'(sd_exp));
    wr(coff, cval);
    check("flag held", 16'(flags[idx]), 16'h0001);
    exp_q.push_back(cval);
    u_rfm_host.xfer(DEV, coff, 8'h00, 1);
    fault_in[idx] = 1'b0;
    cyc(4);
    wr(coff, cval);
    check("flag cleared", 16'(flags[idx]), 16'h0000);
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    $display("timeout");
    stop_test();
  end
  initial
  begin
    rst = 1'b1;
    emerg = 1'b0;
    fault_in = '0;
    seed = 32'h74373CA1;
    cyc(6);
    rst = 1'b0;
    cyc(4);
    check("voltage code", 16'(vcode), 16'h000E);
    check("discharge sel", 16'(dsel), 16'h0001);
    check("term discharge", 16'(tdis), 16'h0000);
    check("rail on", 16'(rail_on), 16'h0000);
    exp_q.push_back(8'hC0);
    exp_q.push_back(8'h37);
    u_rfm_host.xfer(DEV, 8'hA2, 8'h00, 2);
    exp_q.push_back(8'h61);
    exp_q.push_back(8'h7C);
    u_rfm_host.xfer(DEV, 8'hAD, 8'h00, 2);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wr(8'hA2, seed[7:0]);
      wr(8'hA3, seed[15:8] | 8'h80);
      exp_q.push_back(seed[7:0]);
      exp_q.push_back({1'b0, seed[14:8]});
      u_rfm_host.xfer(DEV, 8'hA2, 8'h00, 2);
    end
    // Foreign address: three bytes refused, register untouched
    u_rfm_host.xfer(DEV ^ 7'h01, 8'hA2, ~seed[7:0], 0);
    exp_q.push_back(seed[7:0]);
    u_rfm_host.xfer(DEV, 8'hA2, 8'h00, 1);
    wr(8'hA5, 8'h5A);
    exp_q.push_back(8'h00);
    u_rfm_host.xfer(DEV, 8'hA5, 8'h00, 1);
    for (int b = 1; b >= 0; b--)
    begin
      wr(8'hAD, (b == 1) ? 8'h71 : 8'h61);
      cyc(2);
      check("term discharge", 16'(tdis), 16'(b));
    end
    for (int k = 0; k < 4; k++)
    begin
      seed = xs(seed);
      wr(8'hAE, {2'(k), k[0], seed[3:0], 1'b1});
      cyc(2);
      check("discharge sel", 16'(dsel), 16'(k));
      check("voltage code", 16'(vcode), 16'(seed[3:0]));
      emerg = 1'b1;
      cyc(3);
      check("emergency on", 16'(rail_on), 16'(k[0]));
      emerg = 1'b0;
      cyc(3);
      check("rail on", 16'(rail_on), 16'h0001);
    end
    wr(8'hAE, 8'h20);
    cyc(2);
    check("rail off", 16'(rail_on), 16'h0000);
    wr(8'hA2, 8'h80);
    wr(8'hA3, 8'h37);
    fault_case(rfm_pkg::R_L2, 8'hB2, 8'h80, 0);
    fault_case(rfm_pkg::R_SWA, 8'hB2, 8'h40, 1);
    fault_case(0, 8'hB2, 8'h01, 1);
    fault_case(rfm_pkg::R_A5V, 8'hB3, 8'h20, 0);
    fault_case(rfm_pkg::R_L1, 8'hB3, 8'h10, 0);
    fault_case(rfm_pkg::R_L3, 8'hB3, 8'h01, 0);
    fault_case(rfm_pkg::R_SWB, 8'hB3, 8'h06, 0);
    fault_case(rfm_pkg::R_TERM, 8'hB3, 8'h08, 1);
    wr(8'hA3, 8'h20);
    fault_case(rfm_pkg::R_SWB, 8'hB3, 8'h06, 1);
    fault_case(rfm_pkg::R_L1, 8'hB3, 8'h10, 1);
    fault_case(rfm_pkg::R_L3, 8'hB3, 8'h01, 1);
    check("nack count", 16'(u_rfm_host.nack_count), 16'h0003);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
